/* File: logic/cfba_core.sv */
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "cfba_defines.svh"
module cfba_core #(
  parameter logic [15:0] IMPL_BANKS = 16'hffff
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [20:0] prog_addr,
  input  wire logic [15:0] prog_rdata,
  output logic      [11:0] dmem_addr,
  output logic      [7:0]  dmem_wdata,
  output logic             dmem_we,
  output logic             dmem_re,
  input  wire logic [7:0]  dmem_rdata,
  output logic             phase_one,
  output logic             phase_two,
  output logic             phase_three,
  output logic             phase_four
);
  cfba_pkg::cfba_state_s r_q;
  cfba_pkg::cfba_state_s r_d;
  logic [7:0]  op8;
  logic        opw;
  logic        single;
  logic        two_w;
  logic        mvff2;
  logic        jmp2;
  logic        d_load_bank_literal_instr;
  logic        d_movlw;
  logic        d_bra;
  logic        d_tst;
  logic        d_movwf;
  logic        d_movf;
  logic        rd_en;
  logic        wr_en;
  logic        skip;
  logic        pcl_wr;
  logic        flush;
  logic        da_sfr;
  logic [11:0] fa;
  logic [11:0] rd_a;
  logic [11:0] wr_a;
  logic [7:0]  wr_v;
  logic [7:0]  sfr_v;
  logic [20:0] jmp_t;
  logic [20:0] bra_off;
  logic [20:0] bra_t;
  logic        apb_setup;
  logic        apb_acc;
  logic [31:0] rd_mux;
  logic        unmapped;

  function automatic logic is_sfr(input logic [11:0] a);
    return a >= `CFBA_SFR_BASE;
  endfunction

  function automatic logic dram_ok(input logic [11:0] a);
    return !is_sfr(a) && IMPL_BANKS[a[11:8]]; // see RQ13 see RQ16
  endfunction

  assign op8    = r_q.ir[15:8];
  assign opw    = r_q.ir[15:12] == `CFBA_NIB_OPW;
  assign single = r_q.iok && !r_q.sec;
  // access bit clear: offsets below 80h go to bank 0, the rest to bank 15
  assign fa     = r_q.ir[8] ? {r_q.data_bank_pointer, r_q.ir[7:0]}
                            : {{4{r_q.ir[7]}}, r_q.ir[7:0]}; // see RQ14 see RQ18 see RQ19 see RQ21
  assign two_w  = single && (op8 == `CFBA_OP_GOTO || op8 == `CFBA_OP_CALL ||
                  op8 == `CFBA_OP_LDPTR || r_q.ir[15:12] == `CFBA_NIB_MOVE_FULL_ADDRESS_INSTR); // see RQ10
  assign mvff2  = r_q.iok && r_q.sec && opw && r_q.w1[15:12] == `CFBA_NIB_MOVE_FULL_ADDRESS_INSTR; // see RQ11
  assign jmp2   = r_q.iok && r_q.sec && opw &&
                  (r_q.w1[15:8] == `CFBA_OP_GOTO || r_q.w1[15:8] == `CFBA_OP_CALL);
  assign d_load_bank_literal_instr = single && op8 == `CFBA_OP_LOAD_BANK_LITERAL_INSTR;
  assign d_movlw = single && op8 == `CFBA_OP_MOVLW;
  assign d_bra   = single && r_q.ir[15:11] == `CFBA_OP5_BRA;
  assign d_tst   = single && r_q.ir[15:9] == `CFBA_OP7_TST;
  assign d_movwf = single && r_q.ir[15:9] == `CFBA_OP7_MOVWF;
  assign d_movf  = single && r_q.ir[15:10] == `CFBA_OP6_MOVF;
  assign rd_en  = d_tst || d_movf || mvff2;
  assign rd_a   = mvff2 ? r_q.w1[11:0] : fa; // see RQ17
  assign wr_en  = d_movwf || mvff2;
  assign wr_a   = mvff2 ? r_q.ir[11:0] : fa; // see RQ17
  assign wr_v   = mvff2 ? r_q.opnd : r_q.wreg;
  assign jmp_t  = {r_q.ir[11:0], r_q.w1[7:0], 1'b0}; // see RQ8
  assign bra_off = {{9{r_q.ir[10]}}, r_q.ir[10:0], 1'b0};
  assign bra_t  = r_q.pa + bra_off; // see RQ9
  assign skip   = d_tst && r_q.opnd == 8'h00;
  assign pcl_wr = wr_en && wr_a == `CFBA_ADR_PCL; // see RQ20
  assign flush  = jmp2 || d_bra || skip || pcl_wr;
  assign da_sfr = is_sfr(r_q.da);

  always_comb begin
    case (r_q.da)
      `CFBA_ADR_BANKPTR: sfr_v = {4'h0, r_q.data_bank_pointer}; // see RQ14
      `CFBA_ADR_WREG:    sfr_v = r_q.wreg;
      `CFBA_ADR_PCL:     sfr_v = r_q.pc[7:0];
      default:           sfr_v = 8'h00; // see RQ22
    endcase
  end

  assign apb_setup = psel && !penable;
  assign apb_acc   = psel && penable && r_q.pready;

  always_comb begin
    unmapped = 1'b0;
    case (paddr)
      `CFBA_OFS_CTRL:   rd_mux = {31'h0, r_q.run};
      `CFBA_OFS_STATUS: rd_mux = {26'h0, r_q.z, r_q.sec, r_q.ph};
      `CFBA_OFS_PC:     rd_mux = {11'h0, r_q.pc};
      `CFBA_OFS_BANK:   rd_mux = {28'h0, r_q.data_bank_pointer}; // see RQ14
      `CFBA_OFS_WREG:   rd_mux = {24'h0, r_q.wreg};
      default: begin
        rd_mux   = 32'h0;
        unmapped = 1'b1;
      end
    endcase
  end

  always_comb begin
    r_d = r_q;
    r_d.pready  = apb_setup;
    r_d.pslverr = apb_setup && unmapped;
    if (apb_setup) begin
      r_d.prdata = pwrite ? 32'h0 : rd_mux;
    end
    case (r_q.ph)
      cfba_pkg::PH_ONE: begin
        if (r_q.run) begin
          r_d.ph  = cfba_pkg::PH_TWO; // see RQ1
          r_d.pa  = r_q.pc;
          r_d.pc  = r_q.pc + `CFBA_PC_STEP; // see RQ2 see RQ6 see RQ7
          r_d.da  = rd_a;
          r_d.dre = rd_en && dram_ok(rd_a);
        end
      end
      cfba_pkg::PH_TWO: begin
        r_d.ph   = cfba_pkg::PH_THREE;
        // operand read; unimplemented space reads zero
        r_d.opnd = da_sfr ? sfr_v : (r_q.dre ? dmem_rdata : 8'h00); // see RQ5 see RQ12 see RQ16
        r_d.dre  = 1'b0;
      end
      cfba_pkg::PH_THREE: begin
        r_d.ph  = cfba_pkg::PH_FOUR;
        r_d.da  = wr_a;
        r_d.dwd = wr_v;
        r_d.dwe = wr_en && dram_ok(wr_a); // see RQ5 see RQ16
      end
      cfba_pkg::PH_FOUR: begin
        r_d.ph  = cfba_pkg::PH_ONE;
        r_d.dwe = 1'b0;
        r_d.ir  = prog_rdata; // see RQ2 see RQ3
        r_d.iok = !flush; // see RQ4
        r_d.sec = two_w; // see RQ11
        if (two_w) begin
          r_d.w1 = r_q.ir;
        end
        if (d_movlw) begin
          r_d.wreg = r_q.ir[7:0];
        end
        if (d_movf) begin
          r_d.wreg = r_q.opnd;
          r_d.z    = r_q.opnd == 8'h00; // see RQ16
        end
        if (d_load_bank_literal_instr) begin
          r_d.data_bank_pointer = r_q.ir[3:0]; // see RQ15
        end
        if (wr_en && wr_a == `CFBA_ADR_BANKPTR) begin
          r_d.data_bank_pointer = wr_v[3:0]; // see RQ14
        end
        if (wr_en && wr_a == `CFBA_ADR_WREG) begin
          r_d.wreg = wr_v;
        end
        if (jmp2) begin
          r_d.pc = jmp_t; // see RQ8
        end else if (d_bra) begin
          r_d.pc = bra_t; // see RQ9
        end else if (pcl_wr) begin
          r_d.pc = {r_q.pc[20:8], wr_v[7:1], 1'b0}; // see RQ20 see RQ7
        end
      end
      default: r_d.ph = cfba_pkg::PH_ONE;
    endcase
    if (apb_acc && pwrite && paddr == `CFBA_OFS_CTRL) begin
      r_d.run = pwdata[0];
    end
    if (apb_acc && pwrite && paddr == `CFBA_OFS_BANK) begin
      r_d.data_bank_pointer = pwdata[3:0]; // see RQ14
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q     <= '0; // see RQ23
      r_q.ph  <= cfba_pkg::PH_ONE;
      r_q.run <= `CFBA_RUN_RST;
    end else begin
      r_q <= r_d;
    end
  end

  assign prdata      = r_q.prdata;
  assign pready      = r_q.pready;
  assign pslverr     = r_q.pslverr;
  assign prog_addr   = r_q.pa;
  assign dmem_addr   = r_q.da;
  assign dmem_wdata  = r_q.dwd;
  assign dmem_we     = r_q.dwe;
  assign dmem_re     = r_q.dre;
  assign phase_one   = r_q.ph[0];
  assign phase_two   = r_q.ph[1];
  assign phase_three = r_q.ph[2];
  assign phase_four  = r_q.ph[3];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_q4_jump;
    r_q.ph == cfba_pkg::PH_FOUR && jmp2;
  endsequence

  sequence s_cycle_from_one;
    r_q.ph == cfba_pkg::PH_TWO ##1 r_q.ph == cfba_pkg::PH_THREE ##1
    r_q.ph == cfba_pkg::PH_FOUR ##1 r_q.ph == cfba_pkg::PH_ONE;
  endsequence

  a_phase_rotate: assert property ( // see RQ1
    r_q.ph == cfba_pkg::PH_ONE && r_q.run |=> s_cycle_from_one)
    else $error("phase sequence broken");

  a_pc_step: assert property ( // see RQ2
    r_q.ph == cfba_pkg::PH_ONE && r_q.run |=>
      r_q.pc == $past(r_q.pc) + `CFBA_PC_STEP && r_q.pa == $past(r_q.pc))
    else $error("program counter did not advance by two");

  a_pc_even: assert property ( // see RQ7
    r_q.pc[0] == 1'b0 && prog_addr[0] == 1'b0)
    else $error("program counter odd");

  a_ir_latch: assert property ( // see RQ3
    r_q.ph == cfba_pkg::PH_FOUR && !flush |=> r_q.iok && r_q.ir == $past(prog_rdata))
    else $error("fetched word not latched");

  a_jump_flush: assert property ( // see RQ4
    s_q4_jump |=> !r_q.iok && r_q.pc == $past(jmp_t) ##1 r_q.pa == $past(jmp_t, 2))
    else $error("jump target or flush wrong");

  a_bra_target: assert property ( // see RQ9
    r_q.ph == cfba_pkg::PH_FOUR && d_bra |=>
      !r_q.iok && r_q.pc == $past(r_q.pa) + $past(bra_off))
    else $error("branch displacement wrong");

  a_read_phase: assert property ( // see RQ5
    dmem_re |-> r_q.ph == cfba_pkg::PH_TWO && $past(r_q.ph) == cfba_pkg::PH_ONE)
    else $error("data read outside phase two");

  a_write_phase: assert property ( // see RQ16
    dmem_we |-> r_q.ph == cfba_pkg::PH_FOUR && IMPL_BANKS[dmem_addr[11:8]] &&
      dmem_addr < `CFBA_SFR_BASE)
    else $error("write outside phase four or to unimplemented space");

  a_unimpl_zero: assert property ( // see RQ12
    r_q.ph == cfba_pkg::PH_TWO && !da_sfr && !r_q.dre |=> r_q.opnd == 8'h00)
    else $error("unimplemented read not zero");

  a_bank_load: assert property ( // see RQ15
    r_q.ph == cfba_pkg::PH_FOUR && d_load_bank_literal_instr && !apb_acc |=> r_q.data_bank_pointer == $past(r_q.ir[3:0]))
    else $error("bank pointer not loaded");

  a_opw_alone: assert property ( // see RQ11
    r_q.ph == cfba_pkg::PH_FOUR && single && opw && !apb_acc |=>
      $stable(r_q.wreg) && $stable(r_q.data_bank_pointer) && !r_q.sec && r_q.iok)
    else $error("lone operand word not a no-op");

  a_access_map: assert property ( // see RQ21
    r_q.ph == cfba_pkg::PH_ONE && r_q.run && rd_en && !mvff2 && !r_q.ir[8] |=>
      r_q.da[11:8] == {4{$past(r_q.ir[7])}})
    else $error("fast-access mapping wrong");

  // extra guards on phases, strobes and address forming
  a_phase_onehot: assert property ( // see RQ1
    $onehot(r_q.ph))
    else $error("phase not one-hot");

  a_skip_flush: assert property ( // see RQ11
    r_q.ph == cfba_pkg::PH_FOUR && skip |=> !r_q.iok)
    else $error("skipped word not discarded");

  a_pcl_write: assert property ( // see RQ20
    r_q.ph == cfba_pkg::PH_FOUR && pcl_wr |=>
      !r_q.iok && r_q.pc[7:0] == {$past(wr_v[7:1]), 1'b0})
    else $error("program counter low byte write wrong");

  a_second_mark: assert property ( // see RQ10
    r_q.ph == cfba_pkg::PH_FOUR && two_w |=> r_q.sec && r_q.w1 == $past(r_q.ir))
    else $error("first word of two-word instruction lost");

  a_full_addr: assert property ( // see RQ17
    r_q.ph == cfba_pkg::PH_ONE && r_q.run && mvff2 |=> r_q.da == $past(r_q.w1[11:0]))
    else $error("full-address source wrong");

  a_bank_map: assert property ( // see RQ14
    r_q.ph == cfba_pkg::PH_ONE && r_q.run && rd_en && !mvff2 && r_q.ir[8] |=>
      r_q.da == {$past(r_q.data_bank_pointer), $past(r_q.ir[7:0])})
    else $error("banked address wrong");

  a_strobe_space: assert property ( // see RQ16
    dmem_re |-> dmem_addr < `CFBA_SFR_BASE && IMPL_BANKS[dmem_addr[11:8]])
    else $error("read strobe on unimplemented space");

  a_fetch_hold: assert property ( // see RQ3
    r_q.ph != cfba_pkg::PH_ONE |=> $stable(prog_addr))
    else $error("fetch address moved mid-cycle");

  a_write_strobe: assert property ( // see RQ5
    r_q.ph == cfba_pkg::PH_THREE && wr_en && dram_ok(wr_a) |=>
      dmem_we && dmem_addr == $past(wr_a) && dmem_wdata == $past(wr_v))
    else $error("data write not issued in phase four");

  a_zero_flag: assert property ( // see RQ16
    r_q.ph == cfba_pkg::PH_FOUR && d_movf |=> r_q.z == ($past(r_q.opnd) == 8'h00))
    else $error("zero flag wrong");

  a_ir_hold: assert property ( // see RQ2
    r_q.ph != cfba_pkg::PH_FOUR |=> $stable(r_q.ir) && $stable(r_q.iok))
    else $error("instruction register changed outside phase four");

  a_we_single: assert property ( // see RQ5
    dmem_we |=> !dmem_we)
    else $error("write strobe longer than one cycle");

  a_re_single: assert property ( // see RQ5
    dmem_re |=> !dmem_re)
    else $error("read strobe longer than one cycle");

  // a flushed word must leave W and the zero flag alone
  a_flush_noop: assert property ( // see RQ4
    r_q.ph == cfba_pkg::PH_FOUR && !r_q.iok |=> $stable(r_q.wreg) && $stable(r_q.z))
    else $error("flushed word changed state");

  a_bank_upper: assert property ( // see RQ14
    r_q.ph == cfba_pkg::PH_TWO && r_q.da == `CFBA_ADR_BANKPTR |=> r_q.opnd[7:4] == 4'h0)
    else $error("bank pointer upper bits not zero");

  a_sfr_unused: assert property ( // see RQ22
    r_q.ph == cfba_pkg::PH_TWO && da_sfr && r_q.da != `CFBA_ADR_BANKPTR &&
      r_q.da != `CFBA_ADR_WREG && r_q.da != `CFBA_ADR_PCL |=> r_q.opnd == 8'h00)
    else $error("unused special register not zero");

  a_lone_iok: assert property ( // see RQ23
    r_q.ph == cfba_pkg::PH_FOUR && !r_q.iok |=> !r_q.sec || $past(two_w))
    else $error("second-word mark without first word");
endmodule

/* File: logic/cfba_defines.svh */
// Functional notes
// RQ1: core clock divided by four into four one-hot phases forming one instruction cycle.
// RQ2: program counter advances in phase_one; fetched word latched in phase_four.
// RQ3: fetch of next word overlaps execute of current one; one instruction per cycle.
// RQ4: a program counter change costs two cycles; fetched next word becomes a no-op.
// RQ5: execute: latched at phase_one, operand read in phase_two, result written phase_four.
// RQ6: program memory byte addressed; instruction words start at even addresses.
// RQ7: program counter steps by two; its lowest bit is always zero.
// RQ8: absolute jump and call load their word address into counter bits 20..1.
// RQ9: relative branch offset counts words; byte displacement is twice the offset.
// RQ10: four two-word instructions; second word has top nibble 1111 plus 12 data bits.
// RQ11: 1111-prefixed word right after its first word is operand, alone it is a no-op.
// RQ12: reads of unimplemented data locations return zero.
// RQ13: data memory is 16 banks of 256 bytes, 12-bit or bank plus offset.
// RQ14: bank_pointer gives upper four address bits; its upper four bits read zero.
// RQ15: load_bank_literal_instr writes its literal into bank_pointer.
// RQ16: unimplemented bank writes dropped, reads zero, status flags still updated.
// RQ17: move_full_address_instr uses full 12-bit addresses, ignores bank_pointer.
// RQ18: other data instructions use 8-bit offset with bank_pointer or fast-access mapping.
// RQ19: 256-byte fast-access bank reaches special registers and low bank 0 directly.
// RQ20: write to offset F9h with bank_pointer 0Fh changes the program counter.
// RQ21: access bit set uses bank_pointer; clear maps 00-7F to bank 0, 80-FF to bank 15.
// RQ22: special registers fill F80h-FFFh; unused ones there read zero.
// RQ23: after reset the pipeline is empty; first cycle fetches while executing a no-op.
`ifndef CFBA_DEFINES_SVH
`define CFBA_DEFINES_SVH
`define CFBA_OFS_CTRL    8'h00
`define CFBA_OFS_STATUS  8'h04
`define CFBA_OFS_PC      8'h08
`define CFBA_OFS_BANK    8'h0c
`define CFBA_OFS_WREG    8'h10
`define CFBA_RUN_RST     1'b1
`define CFBA_PC_STEP     21'h2
`define CFBA_SFR_BASE    12'hf80
`define CFBA_ADR_BANKPTR 12'hfe0
`define CFBA_ADR_WREG    12'hfe8
`define CFBA_ADR_PCL     12'hff9
`define CFBA_OP_LOAD_BANK_LITERAL_INSTR    8'h01
`define CFBA_OP_MOVLW    8'h0e
`define CFBA_OP_GOTO     8'hef
`define CFBA_OP_CALL     8'hec
`define CFBA_OP_LDPTR    8'hee
`define CFBA_NIB_MOVE_FULL_ADDRESS_INSTR   4'hc
`define CFBA_NIB_OPW     4'hf
`define CFBA_OP5_BRA     5'h1a
`define CFBA_OP7_TST     7'h33
`define CFBA_OP7_MOVWF   7'h37
`define CFBA_OP6_MOVF    6'h14
`endif

/* File: logic/cfba_pkg.sv */
package cfba_pkg;
  typedef enum logic [3:0] {
    PH_ONE   = 4'h1,
    PH_TWO   = 4'h2,
    PH_THREE = 4'h4,
    PH_FOUR  = 4'h8
  } cfba_phase_e;

  typedef struct packed {
    cfba_phase_e ph;
    logic [20:0] pc;
    logic [20:0] pa;
    logic [15:0] ir;
    logic        iok;
    logic        sec;
    logic [15:0] w1;
    logic [3:0]  data_bank_pointer;
    logic [7:0]  wreg;
    logic        z;
    logic [7:0]  opnd;
    logic [11:0] da;
    logic [7:0]  dwd;
    logic        dwe;
    logic        dre;
    logic        run;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } cfba_state_s;
endpackage

/* File: test/cfba_mem_model.sv */
`timescale 1ns/1ns
module cfba_mem_model (
  input  wire logic        pclk,
  input  wire logic [20:0] prog_addr,
  output logic      [15:0] prog_rdata,
  input  wire logic [11:0] dmem_addr,
  input  wire logic [7:0]  dmem_wdata,
  input  wire logic        dmem_we,
  input  wire logic        dmem_re,
  output logic      [7:0]  dmem_rdata
);
  logic [15:0] prog [0:127];
  logic [7:0]  ram  [0:4095];

  initial begin
    for (int i = 0; i < 128; i++) prog[i] = 16'hf000;
    for (int i = 0; i < 4096; i++) ram[i] = 8'h00;
  end

  // word index drops the byte bit; outside the array a lone operand word
  assign prog_rdata = (prog_addr[20:8] == 13'h0) ? prog[prog_addr[7:1]] : 16'hf000;
  // unstrobed reads show inverted data so a missing strobe cannot pass
  assign dmem_rdata = dmem_re ? ram[dmem_addr] : ~ram[dmem_addr];

  always @(posedge pclk) begin
    if (dmem_we) ram[dmem_addr] <= dmem_wdata;
  end
endmodule

/* File: test/cpu_fetch_pipeline_bank_addressing_tb.sv */
`timescale 1ns/1ns
`include "cfba_defines.svh"
module cpu_fetch_pipeline_bank_addressing_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        dmem_we, dmem_re, phase_one, phase_two, phase_three, phase_four;
  logic [7:0]  paddr, dmem_wdata, dmem_rdata;
  logic [31:0] pwdata, prdata, rd;
  logic [20:0] prog_addr;
  logic [15:0] prog_rdata;
  logic [11:0] dmem_addr;
  int          num_errors;
  int          comparisons;
  localparam logic [23:0] PRG [34] = '{
    24'h000e55, 24'h020103, 24'h046f20, 24'h066e10, 24'h08c320, 24'h0af456, 24'h0cef20,
    24'h0ef000, 24'h100eaa, 24'h406e11, 24'h426600, 24'h44c011, 24'h46f012, 24'h486e13,
    24'h4ad002, 24'h4c0e77, 24'h4e0e77, 24'h506e14, 24'h52010f, 24'h540e60, 24'h566ff9,
    24'h580ebb, 24'h606e15, 24'h620102, 24'h646f30, 24'h665130, 24'h686e16, 24'h6aec38,
    24'h6cf000, 24'h70ee00, 24'h72f123, 24'h746e17, 24'h76ef3b, 24'h78f000};

  cfba_core #(.IMPL_BANKS(16'hfffb)) uut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .prog_addr, .prog_rdata, .dmem_addr, .dmem_wdata, .dmem_we, .dmem_re,
    .dmem_rdata, .phase_one, .phase_two, .phase_three, .phase_four);
  cfba_mem_model mem (
    .pclk, .prog_addr, .prog_rdata, .dmem_addr, .dmem_wdata, .dmem_we, .dmem_re,
    .dmem_rdata);

  always #25 pclk = ~pclk;

  task stop_test;
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task ram_is(input logic [11:0] a, input logic [7:0] v);
    check({24'h0, mem.ram[a]}, {24'h0, v}, "data ram");
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task t_phase;
    @(negedge pclk);
    for (int i = 0; i < 12; i++) begin
      check({28'h0, phase_four, phase_three, phase_two, phase_one}, 32'h1 << (i % 4), "phase");
      if (i == 1) check({11'h0, prog_addr}, 32'h0, "first fetch");
      if (i == 5) check({11'h0, prog_addr}, 32'h2, "pc step");
      @(negedge pclk);
    end
  endtask

  task t_regs;
    logic [31:0] p;
    apb(1'b0, `CFBA_OFS_CTRL, 32'h0, rd, er);
    check(rd, 32'h1, "ctrl reset");
    apb(1'b1, `CFBA_OFS_CTRL, 32'h0, rd, er);
    apb(1'b1, `CFBA_OFS_BANK, 32'hff, rd, er);
    apb(1'b0, `CFBA_OFS_BANK, 32'h0, rd, er);
    check(rd, 32'h0f, "bank upper bits");
    apb(1'b0, `CFBA_OFS_PC, 32'h0, p, er);
    apb(1'b0, `CFBA_OFS_PC, 32'h0, rd, er);
    check(rd, p, "pc frozen");
    check({31'h0, rd[0]}, 32'h0, "pc lsb");
    apb(1'b0, `CFBA_OFS_STATUS, 32'h0, rd, er);
    check({28'h0, rd[3:0]}, 32'h1, "frozen phase");
    apb(1'b0, 8'h20, 32'h0, rd, er);
    check({rd[31:1], er}, 32'h1, "unmapped");
    apb(1'b1, `CFBA_OFS_CTRL, 32'h1, rd, er);
  endtask

  task t_prog;
    int i;
    @(posedge pclk);
    presetn <= 1'b0;
    for (i = 0; i < 34; i++) mem.prog[PRG[i][23:17]] = PRG[i][15:0];
    mem.ram[12'h230] = 8'h5a;
    mem.ram[12'h016] = 8'hcc;
    mem.ram[12'h017] = 8'hcc;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    i = 0;
    while (mem.ram[12'h017] !== 8'h00 && i < 1000) begin
      @(posedge pclk);
      i++;
    end
    ram_is(12'h320, 8'h55);
    ram_is(12'h010, 8'h55);
    ram_is(12'h456, 8'h55);
    ram_is(12'h011, 8'h55);
    ram_is(12'h012, 8'h00);
    ram_is(12'h013, 8'h55);
    ram_is(12'h014, 8'h55);
    ram_is(12'h015, 8'h60);
    ram_is(12'h230, 8'h5a);
    ram_is(12'h016, 8'h00);
    ram_is(12'h017, 8'h00);
    apb(1'b0, `CFBA_OFS_BANK, 32'h0, rd, er);
    check(rd, 32'h2, "bank literal");
    apb(1'b0, `CFBA_OFS_STATUS, 32'h0, rd, er);
    check({31'h0, rd[5]}, 32'h1, "zero flag");
  endtask

  initial begin
    pclk        = 1'b0;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    num_errors  = 0;
    comparisons = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_phase;
    t_regs;
    t_prog;
    stop_test;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    stop_test;
  end
endmodule
